//--- vector_table_placement_ctrl.sv
// Purpose: Control register holding vector select, change enable, pull-up
//          disable; derives vector base, reset address, interrupt blocking.
// Assumes: Core presents one write or read per cycle on the register port.
// Notes: Fuses and lock bits are static straps, synchronised anyway.
// Behaviour
// - Select zero puts vectors at flash start, one at boot section start.
// - Boot section start comes from the boot size fuses.
// - Select changes only while change-enable is set.
// - Interrupts blocked from change-enable write until the instruction after the select write ends.
// - Without a select write interrupts stay blocked for the write cycle plus four.
// - Automatic blocking never touches the global interrupt flag.
// - Change-enable clears after four cycles or on the select write.
// - Vectors in boot and app lock programmed block interrupts in app.
// - Vectors in app and boot lock programmed block interrupts in boot.
// - Pull-up disable forces every port pull-up off.
// - Register answers at data address 0x55 and I/O address 0x35.
// - Reset clears the control register to zero.
// - With a 2K boot section relocated vectors start at 0x1C02.
// - Boot reset fuse programmed with 2K boot starts at 0x1C00.
// - Relocated vector address is table address plus boot start.
// - Reset address comes from the boot reset fuse, 0x000 otherwise.
`timescale 1ns/1ps
module vector_table_placement_ctrl #(
    parameter int PORT_PINS = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] data_addr,
    input wire logic data_write,
    input wire logic data_read,
    input wire logic [5:0] io_addr,
    input wire logic io_write,
    input wire logic io_read,
    input wire logic [7:0] write_data,
    output logic [7:0] read_data,
    input wire logic instr_done,
    input wire logic [1:0] boot_size_fuses,
    input wire logic boot_reset_fuse,
    input wire logic app_section_lock_bit,
    input wire logic boot_section_lock_bit,
    input wire logic exec_in_boot,
    input wire logic [PORT_PINS-1:0] pin_direction_bit,
    input wire logic [PORT_PINS-1:0] pin_output_bit,
    output logic [PORT_PINS-1:0] pullup_enable,
    output logic [vector_ctrl_pkg::PC_WIDTH-1:0] vector_base,
    output logic [vector_ctrl_pkg::PC_WIDTH-1:0] reset_address,
    output logic irq_block
);
    import vector_ctrl_pkg::*;

    initial begin
        if (PORT_PINS < 1) begin
            $error("PORT_PINS must be at least one");
        end
    end

    // ------------------------------------------------------------
    // Reset release and strap synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic rst_n;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Fuses and locks are pins; two stages keep metastability out.
    logic [4:0] strap_s1_r;
    logic [4:0] strap_s2_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_s1_r <= 5'h1f;
            strap_s2_r <= 5'h1f;
        end else begin
            strap_s1_r <= {boot_size_fuses, boot_reset_fuse,
                           app_section_lock_bit, boot_section_lock_bit};
            strap_s2_r <= strap_s1_r;
        end
    end
    wire [1:0] size_q = strap_s2_r[4:3];
    wire boot_rst_q = strap_s2_r[2];
    wire app_lock_q = strap_s2_r[1];
    wire boot_lock_q = strap_s2_r[0];

    // ------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------
    wire data_hit = (data_addr == DATA_ADDR);
    wire io_hit = (io_addr == IO_ADDR);
    wire wr_hit = (data_write && data_hit) || (io_write && io_hit);
    wire rd_hit = (data_read && data_hit) || (io_read && io_hit);

    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [2:0] window_r;
    logic [2:0] window_nxt;
    logic tail_r;
    logic tail_nxt;
    logic [7:0] read_data_r;

    wire change_on = ctrl_r[BIT_CHANGE];
    wire set_change = wr_hit && write_data[BIT_CHANGE];
    // A write with change-enable low while armed is the select write.
    wire sel_write = wr_hit && change_on && !write_data[BIT_CHANGE];
    wire window_end = (window_r == 3'(CHANGE_CYCLES - 1));

    // ------------------------------------------------------------
    // Control register next state
    // ------------------------------------------------------------
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_hit) begin
            ctrl_nxt[BIT_PULLUP] = write_data[BIT_PULLUP];
        end
        if (sel_write) begin
            ctrl_nxt[BIT_SELECT] = write_data[BIT_SELECT];
            ctrl_nxt[BIT_CHANGE] = 1'b0;
        end else if (set_change) begin
            ctrl_nxt[BIT_CHANGE] = 1'b1;
        end else if (change_on && window_end) begin
            ctrl_nxt[BIT_CHANGE] = 1'b0;
        end
        ctrl_nxt = ctrl_nxt & CTRL_MASK;
    end

    // Counts cycles since change-enable was written.
    always_comb begin
        window_nxt = 3'h0;
        if (set_change && !sel_write) begin
            window_nxt = 3'h0;
        end else if (change_on && !sel_write && !window_end) begin
            window_nxt = window_r + 3'h1;
        end
    end

    // After the select write, hold the block until the next instruction ends.
    always_comb begin
        tail_nxt = tail_r;
        if (sel_write) begin
            tail_nxt = 1'b1;
        end else if (tail_r && instr_done) begin
            tail_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RESET;
            window_r <= 3'h0;
            tail_r <= 1'b0;
            read_data_r <= 8'h00;
        end else begin
            ctrl_r <= ctrl_nxt;
            window_r <= window_nxt;
            tail_r <= tail_nxt;
            read_data_r <= rd_hit ? ctrl_r : 8'h00;
        end
    end
    assign read_data = read_data_r;

    // ------------------------------------------------------------
    // Vector placement and interrupt gating
    // ------------------------------------------------------------
    logic [PC_WIDTH-1:0] boot_start;
    boot_start_decode u_boot_start (
        .boot_size_fuses(size_q),
        .boot_start(boot_start)
    );

    wire relocated = ctrl_r[BIT_SELECT];
    // Relocated base is boot start plus the normal offset.
    assign vector_base = relocated ? (boot_start + VECTOR_OFFSET) :
                         VECTOR_OFFSET;
    // Fuses are active low: zero means programmed.
    assign reset_address = boot_rst_q ? RESET_DEFAULT : boot_start;

    // Lock bits are active low as well.
    wire lock_block = (relocated && !app_lock_q && !exec_in_boot) ||
                      (!relocated && !boot_lock_q && exec_in_boot);
    // Only a mask toward the core; the global flag is never written here.
    assign irq_block = set_change || change_on || tail_r ||
                       lock_block;

    // ------------------------------------------------------------
    // Port pull-ups
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < PORT_PINS; gi++) begin : g_pull
            assign pullup_enable[gi] = !pin_direction_bit[gi] &&
                pin_output_bit[gi] && !ctrl_r[BIT_PULLUP];
        end
    endgenerate

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_change_expires: assert property (@(posedge clk) disable iff (!rst_n)
        (set_change && !change_on) ##1 (change_on && !wr_hit) [*4]
        |=> !change_on)
        else $error("change enable did not clear after four cycles");
    a_select_guard: assert property (@(posedge clk) disable iff (!rst_n)
        (!change_on) |=> $stable(ctrl_r[BIT_SELECT]))
        else $error("select changed without change enable");
    a_block_on_set: assert property (@(posedge clk) disable iff (!rst_n)
        set_change |-> irq_block ##1 irq_block)
        else $error("interrupts not blocked on change enable");
    a_select_clears: assert property (@(posedge clk) disable iff (!rst_n)
        sel_write |=> !change_on && tail_r)
        else $error("select write did not end window");
    a_pullup_off: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_r[BIT_PULLUP] |-> (pullup_enable == '0))
        else $error("pull-up on while disabled");
    a_vector_base: assert property (@(posedge clk) disable iff (!rst_n)
        relocated |-> vector_base == boot_start + VECTOR_OFFSET)
        else $error("relocated vector base wrong");
    a_reset_addr: assert property (@(posedge clk) disable iff (!rst_n)
        boot_rst_q |-> reset_address == RESET_DEFAULT)
        else $error("reset address wrong");
    a_app_lock: assert property (@(posedge clk) disable iff (!rst_n)
        (relocated && !app_lock_q && !exec_in_boot) |-> irq_block)
        else $error("app lock did not block interrupts");
    a_boot_lock: assert property (@(posedge clk) disable iff (!rst_n)
        (!relocated && !boot_lock_q && exec_in_boot) |-> irq_block)
        else $error("boot lock did not block interrupts");
endmodule // vector_table_placement_ctrl

//--- vector_ctrl_pkg.sv
// Purpose: Shared constants for the vector table placement control.
// Assumes: Word-addressed program flash, 8-bit control register.
// Notes: Boot section sizes follow the two-bit boot size fuse code.
package vector_ctrl_pkg;
    localparam logic [7:0] DATA_ADDR = 8'h55;
    localparam logic [7:0] IO_OFFSET = 8'h20;
    localparam logic [5:0] IO_ADDR = 6'h35;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int BIT_CHANGE = 0;
    localparam int BIT_SELECT = 1;
    localparam int BIT_PULLUP = 4;
    localparam logic [7:0] CTRL_MASK = 8'h13;
    localparam int CHANGE_CYCLES = 4;
    localparam int PC_WIDTH = 13;
    localparam logic [12:0] VECTOR_OFFSET = 13'h0002;
    localparam logic [12:0] RESET_DEFAULT = 13'h0000;
    // Boot start word address for fuse codes 0..3 (largest section first).
    localparam logic [12:0] BOOT_START_0 = 13'h1800;
    localparam logic [12:0] BOOT_START_1 = 13'h1c00;
    localparam logic [12:0] BOOT_START_2 = 13'h1e00;
    localparam logic [12:0] BOOT_START_3 = 13'h1f00;
endpackage

//--- boot_start_decode.sv
// Purpose: Map the boot size fuse code to the boot section start address.
// Assumes: Fuses are static while the part runs.
// Notes: Purely combinational.
`timescale 1ns/1ps
module boot_start_decode (
    input wire logic [1:0] boot_size_fuses,
    output logic [vector_ctrl_pkg::PC_WIDTH-1:0] boot_start
);
    import vector_ctrl_pkg::*;
    assign boot_start = (boot_size_fuses == 2'h0) ? BOOT_START_0 :
                        (boot_size_fuses == 2'h1) ? BOOT_START_1 :
                        (boot_size_fuses == 2'h2) ? BOOT_START_2 :
                        BOOT_START_3;
endmodule // boot_start_decode

//--- vector_table_placement_ctrl_bench.sv
// Purpose: Self-checking bench for the vector table placement control.
// Assumes: Straps settle after three cycles; one access per strobe.
// Notes: Scenario tasks drive the ports by non-blocking assignment.
`timescale 1ns/1ps
module vector_table_placement_ctrl_bench;
    import vector_ctrl_pkg::*;
    // ------------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------------
    logic clk = 0, reset_n = 0, instr_done = 0, exec_in_boot = 0;
    logic data_write = 0, data_read = 0, io_write = 0, io_read = 0;
    logic boot_reset_fuse = 1, app_section_lock_bit = 1;
    logic boot_section_lock_bit = 1;
    logic [7:0] data_addr = 8'h00, write_data = 8'h00, read_data, rd_val;
    logic [7:0] pin_direction_bit = 8'h0f, pin_output_bit = 8'hff;
    logic [7:0] pullup_enable;
    logic [5:0] io_addr = 6'h00;
    logic [1:0] boot_size_fuses = 2'h1;
    logic [12:0] vector_base, reset_address;
    logic irq_block;
    logic [12:0] starts [4] = '{BOOT_START_0, BOOT_START_1, BOOT_START_2,
                                BOOT_START_3};
    int num_errors = 0, samples_checked = 0, cycles = 0;
    always #2 clk = ~clk;
    vector_table_placement_ctrl i_vector_table_placement_ctrl (
        .clk(clk), .reset_n(reset_n), .data_addr(data_addr),
        .data_write(data_write), .data_read(data_read), .io_addr(io_addr),
        .io_write(io_write), .io_read(io_read), .write_data(write_data),
        .read_data(read_data), .instr_done(instr_done),
        .boot_size_fuses(boot_size_fuses), .boot_reset_fuse(boot_reset_fuse),
        .app_section_lock_bit(app_section_lock_bit),
        .boot_section_lock_bit(boot_section_lock_bit),
        .exec_in_boot(exec_in_boot), .pin_direction_bit(pin_direction_bit),
        .pin_output_bit(pin_output_bit), .pullup_enable(pullup_enable),
        .vector_base(vector_base), .reset_address(reset_address),
        .irq_block(irq_block));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task chk_val(input logic [12:0] got, input logic [12:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chk_flag(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task tally_and_finish;
        $display("checks=%0d errors=%0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // The strobe is held for exactly one edge so each access is taken once.
    task wr(input logic io, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        data_addr <= a; io_addr <= a[5:0]; write_data <= d;
        data_write <= !io; io_write <= io;
        @(posedge clk);
        data_write <= 0; io_write <= 0; #1;
    endtask
    task rd(input logic io, input logic [7:0] a);
        @(posedge clk);
        data_addr <= a; io_addr <= a[5:0]; data_read <= !io; io_read <= io;
        @(posedge clk);
        data_read <= 0; io_read <= 0; #1;
        rd_val = read_data;
    endtask
    task pulse_instr;
        @(posedge clk); instr_done <= 1;
        @(posedge clk); instr_done <= 0;
        step(1);
    endtask
    task move(input logic [7:0] sel);
        wr(0, DATA_ADDR, 8'h01);
        wr(0, DATA_ADDR, sel);
        pulse_instr;
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_reset;
        rd(0, DATA_ADDR); chk_val(rd_val, 8'h00);
        chk_val(vector_base, 13'h0002);
        chk_val(reset_address, 13'h0000);
        chk_flag(irq_block, 0);
    endtask
    task t_pullup;
        chk_val(pullup_enable, 8'hf0);
        wr(0, 8'h35, 8'h10);
        chk_val(pullup_enable, 8'hf0);
        wr(1, {2'h0, IO_ADDR}, 8'h10);
        chk_val(pullup_enable, 8'h00);
        rd(0, DATA_ADDR); chk_val(rd_val, 8'h10);
        rd(1, {2'h0, IO_ADDR}); chk_val(rd_val, 8'h10);
        rd(0, 8'h54); chk_val(rd_val, 8'h00);
        wr(0, DATA_ADDR, 8'h00);
        chk_val(pullup_enable, 8'hf0);
    endtask
    task t_relocate;
        wr(0, DATA_ADDR, 8'h02);
        rd(0, DATA_ADDR); chk_val(rd_val, 8'h00);
        wr(0, DATA_ADDR, 8'h01); chk_flag(irq_block, 1);
        wr(0, DATA_ADDR, 8'h02); chk_val(vector_base, 13'h1c02);
        step(2); chk_flag(irq_block, 1);
        pulse_instr; chk_flag(irq_block, 0);
        rd(0, DATA_ADDR); chk_val(rd_val, 8'h02);
    endtask
    task t_timeout;
        wr(0, DATA_ADDR, 8'h03); chk_flag(irq_block, 1);
        step(2); chk_flag(irq_block, 1);
        step(1); chk_flag(irq_block, 1);
        step(1); chk_flag(irq_block, 0);
        rd(0, DATA_ADDR); chk_val(rd_val, 8'h02);
        wr(0, DATA_ADDR, 8'h00);
        rd(0, DATA_ADDR); chk_val(rd_val, 8'h02);
    endtask
    task t_locks;
        @(posedge clk); app_section_lock_bit <= 0;
        step(3); chk_flag(irq_block, 1);
        exec_in_boot <= 1;
        step(3); chk_flag(irq_block, 0);
        app_section_lock_bit <= 1;
        move(8'h00); chk_val(vector_base, 13'h0002);
        @(posedge clk); boot_section_lock_bit <= 0;
        step(3); chk_flag(irq_block, 1);
        exec_in_boot <= 0;
        step(3); chk_flag(irq_block, 0);
        boot_section_lock_bit <= 1;
    endtask
    task t_fuses;
        move(8'h02);
        @(posedge clk); boot_reset_fuse <= 0;
        for (int c = 0; c < 4; c++) begin
            boot_size_fuses <= 2'(c);
            step(3);
            chk_val(vector_base, starts[c] + 13'h0002);
            chk_val(reset_address, starts[c]);
        end
        boot_size_fuses <= 2'h1;
        step(3); chk_val(reset_address, 13'h1c00);
        boot_reset_fuse <= 1;
        step(3); chk_val(reset_address, 13'h0000);
    endtask
    // ------------------------------------------------------------------
    // Sequence and hang guard
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1;
        step(3);
        t_reset;
        t_pullup;
        t_relocate;
        t_timeout;
        t_locks;
        t_fuses;
        tally_and_finish;
    end
endmodule // vector_table_placement_ctrl_bench
